// *** rtl/urw_rx_dev.sv ***
// receive end: bit sampler, two-word character buffer, error flags,
// address filter and wake-on-break
// assumes rx_line comes from another domain; software strobes are on clk
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module urw_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] i);
    if (i == AW'(DEPTH - 1)) begin
      return '0;
    end
    return i + 1'b1;
  endfunction : bump

  assign in_ready  = (cnt_r != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (clr) begin
        wr_r  <= '0;
        rd_r  <= '0;
        cnt_r <= '0;
      end else begin
        if (push) begin
          wr_r <= bump(wr_r);
        end
        if (pop) begin
          rd_r <= bump(rd_r);
        end
        if (push && !pop) begin
          cnt_r <= cnt_r + 1'b1;
        end else if (pop && !push) begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end
endmodule : urw_fifo
////////////////////////////////////////////////////////////////////////////////
// Operation
// - store framing error with every character
// - flags show oldest character; read pops
// - framing flag cleared only by read or port disable
// - framing error neither stops reception nor interrupts
// - third complete character while full sets overrun
// - overrun blocks intake; enables clear it
// - nine-bit mode; ninth bit shown separately
// - address mode with nine-bit mode keeps only ninth-bit-set characters
// - software drops address mode after match
// - wake only async; no reception asleep
// - wake mode suppresses reception, watches falling edge
// - wake falling edge sets receive interrupt
// - data read clears wake interrupt
// - line rising edge ends break, clears wake
// - non-zero character: first low is wake
// - sender breaks ten or more bit times
// - sender leaves time for oscillator start
// - software checks idle before enabling wake
module urw_rx_dev
  import urw_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  urw_line_if.dev     line,
  input  wire logic   serial_port_enable,
  input  wire logic   continuous_rx_enable,
  input  wire logic   nine_bit_rx_select,
  input  wire logic   address_detect_enable,
  input  wire logic   wakeup_set,
  input  wire logic   sleep,
  input  wire logic   rd_data,
  output logic [7:0]  rx_data_reg,
  output logic        rx_ninth_bit,
  output logic        frame_err_flag,
  output logic        overrun_err_flag,
  output logic        rx_interrupt_flag,
  output logic        wakeup_enable,
  output logic        rx_idle_status
);
  logic             sync1_r;
  logic             sync2_r;
  logic             prev_r;
  logic             fall;
  logic             rise;
  urw_rx_st_t       st_r;
  logic [CNT_W-1:0] cnt_r;
  logic [3:0]       bitn_r;
  logic [8:0]       rx_shift_register;
  logic             done_r;
  logic             stop_bad_r;
  logic             run;
  logic [8:0]       char_val;
  logic             keep;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [RX_W-1:0]  fifo_out_data;
  logic             push;
  logic             pop;
  logic             wake_low_r;
  logic             wake_irq_r;

  assign fall = prev_r & ~sync2_r;
  assign rise = ~prev_r & sync2_r;
  // wake mode and sleep both hold the sampler off
  assign run  = serial_port_enable & continuous_rx_enable & ~wakeup_enable
              & ~sleep;
  assign char_val = nine_bit_rx_select ? rx_shift_register
                  : {1'b0, rx_shift_register[8:1]};
  assign keep = ~(address_detect_enable & nine_bit_rx_select
                & ~char_val[8]);
  assign push = done_r & keep & ~overrun_err_flag;
  assign pop  = rd_data & fifo_out_valid;

  ////////////////////////////////////////////////////////////////////////////
  // line synchroniser; only the second stage is looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= LINE_IDLE;
      sync2_r <= LINE_IDLE;
      prev_r  <= LINE_IDLE;
    end else if (ce) begin
      sync1_r <= line.rx_line;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit sampler
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r              <= RX_IDLE;
      cnt_r             <= '0;
      bitn_r            <= '0;
      rx_shift_register <= '0;
      done_r            <= 1'b0;
      stop_bad_r        <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (!run) begin
        st_r  <= RX_IDLE;
        cnt_r <= '0;
      end else begin
        unique case (st_r)
          RX_IDLE: begin
            cnt_r <= '0;
            if (fall) begin
              st_r <= RX_START;
            end
          end
          RX_START: begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == HALF_LAST) begin
              cnt_r  <= '0;
              bitn_r <= '0;
              // a glitch that is high again at mid-bit is dropped
              st_r   <= sync2_r ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == BIT_LAST) begin
              cnt_r             <= '0;
              rx_shift_register <= {sync2_r, rx_shift_register[8:1]};
              bitn_r            <= bitn_r + 1'b1;
              if (bitn_r == (nine_bit_rx_select ? BITS_9 : BITS_8) - 4'h1)
              begin
                st_r <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == BIT_LAST) begin
              stop_bad_r <= ~sync2_r;
              done_r     <= 1'b1;
              st_r       <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // character buffer; port disable flushes it, receive disable does not
  urw_fifo #(
    .W     (RX_W),
    .DEPTH (RX_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .clr       (~serial_port_enable),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({stop_bad_r, char_val}),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // overrun: held until either enable drops
  always_ff @(posedge clk) begin
    if (rst) begin
      overrun_err_flag <= 1'b0;
    end else if (ce) begin
      if (!serial_port_enable || !continuous_rx_enable) begin
        overrun_err_flag <= 1'b0;
      end else if (push && !fifo_in_ready) begin
        overrun_err_flag <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake on break; runs in sleep too, standing in for the async path
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeup_enable <= 1'b0;
      wake_low_r    <= 1'b0;
    end else if (ce) begin
      if (!serial_port_enable) begin
        wakeup_enable <= 1'b0;
        wake_low_r    <= 1'b0;
      end else if (wakeup_enable) begin
        if (fall) begin
          wake_low_r <= 1'b1;
        end else if (wake_low_r && rise) begin
          wakeup_enable <= 1'b0;
          wake_low_r    <= 1'b0;
        end
      end else if (wakeup_set) begin
        wakeup_enable <= 1'b1;
        wake_low_r    <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_irq_r <= 1'b0;
    end else if (ce) begin
      if (!serial_port_enable) begin
        wake_irq_r <= 1'b0;
      end else if (wakeup_enable && fall) begin
        wake_irq_r <= 1'b1;
      end else if (rd_data) begin
        wake_irq_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered views; framing error never feeds the interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_data_reg       <= '0;
      rx_ninth_bit      <= 1'b0;
      frame_err_flag    <= 1'b0;
      rx_interrupt_flag <= 1'b0;
      rx_idle_status    <= 1'b1;
    end else if (ce) begin
      rx_data_reg       <= fifo_out_valid ? fifo_out_data[7:0] : '0;
      rx_ninth_bit      <= fifo_out_valid & fifo_out_data[RX_NINTH_BIT];
      frame_err_flag    <= fifo_out_valid & fifo_out_data[RX_FRM_BIT];
      rx_interrupt_flag <= fifo_out_valid | wake_irq_r;
      rx_idle_status    <= (st_r == RX_IDLE);
    end
  end
endmodule : urw_rx_dev
`default_nettype wire

// *** rtl/urw_pkg.sv ***
// shared constants of the serial receive block and its remote sender
// assumes one 200 MHz clock on both ends and a fixed bit period
`default_nettype none
package urw_pkg;
  localparam int          CLK_MHZ       = 200;
  // baud generator lies outside this block: bit period is fixed here
  localparam int          BIT_CYC       = 16;
  localparam int          HALF_CYC      = BIT_CYC / 2;
  localparam int          CNT_W         = 8;
  localparam logic [7:0]  BIT_LAST      = 8'(BIT_CYC - 1);
  localparam logic [7:0]  HALF_LAST     = 8'(HALF_CYC - 1);
  localparam int          RX_DEPTH      = 2;
  localparam int          TX_DEPTH      = 4;
  localparam int          RX_W          = 10;
  localparam int          TX_W          = 9;
  localparam int          RX_FRM_BIT    = 9;
  localparam int          RX_NINTH_BIT  = 8;
  localparam logic [3:0]  BITS_8        = 4'h8;
  localparam logic [3:0]  BITS_9        = 4'h9;
  localparam logic [3:0]  BRK_BITS      = 4'hD;
  localparam logic [3:0]  BRK_GAP_BITS  = 4'h2;
  localparam logic        LINE_IDLE     = 1'b1;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} urw_rx_st_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP,
                            TX_BRK, TX_GAP} urw_tx_st_t;
endpackage : urw_pkg
`default_nettype wire

// *** rtl/urw_line_if.sv ***
// serial line between the remote sender and the receive block
// assumes the testbench ties both ends to one instance
`default_nettype none
interface urw_line_if;
  logic rx_line;
  modport dev (input rx_line);
  modport rmt (output rx_line);
endinterface : urw_line_if
`default_nettype wire

// *** rtl/urw_tx_rmt.sv ***
// remote sender: four-word buffer feeding an 8/9-bit serializer,
// plus an all-zero break with a trailing idle gap
// assumes user strobes on clk; line is read by the receive end
`default_nettype none
module urw_tx_rmt
  import urw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  urw_line_if.rmt         line,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [8:0] tx_data,
  input  wire logic       nine_bit,
  input  wire logic       send_break,
  output logic            tx_busy
);
  urw_tx_st_t       st_r;
  logic [CNT_W-1:0] cnt_r;
  logic [3:0]       bitn_r;
  logic [8:0]       sh_r;
  logic             line_r;
  logic             brk_pend_r;
  logic             q_valid;
  logic [8:0]       q_data;
  logic             q_take;
  logic             bit_end;

  assign bit_end       = (cnt_r == BIT_LAST);
  assign q_take        = (st_r == TX_IDLE) & q_valid & ~brk_pend_r;
  assign line.rx_line  = line_r;

  // serializer stalls the buffer, so a burst really fills it
  urw_fifo #(
    .W     (TX_W),
    .DEPTH (TX_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .clr       (1'b0),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (q_valid),
    .out_ready (q_take),
    .out_data  (q_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      brk_pend_r <= 1'b0;
    end else if (ce) begin
      if (send_break) begin
        brk_pend_r <= 1'b1;
      end else if (st_r == TX_IDLE) begin
        brk_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r    <= TX_IDLE;
      cnt_r   <= '0;
      bitn_r  <= '0;
      sh_r    <= '0;
      line_r  <= LINE_IDLE;
      tx_busy <= 1'b0;
    end else if (ce) begin
      cnt_r <= bit_end ? '0 : cnt_r + 1'b1;
      unique case (st_r)
        TX_IDLE: begin
          cnt_r   <= '0;
          bitn_r  <= '0;
          line_r  <= LINE_IDLE;
          tx_busy <= brk_pend_r | q_valid;
          if (brk_pend_r) begin
            st_r   <= TX_BRK;
            line_r <= ~LINE_IDLE;
          end else if (q_valid) begin
            st_r   <= TX_START;
            sh_r   <= q_data;
            line_r <= ~LINE_IDLE;
          end
        end
        TX_START: begin
          if (bit_end) begin
            st_r   <= TX_DATA;
            line_r <= sh_r[0];
            sh_r   <= {1'b0, sh_r[8:1]};
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            bitn_r <= bitn_r + 1'b1;
            if (bitn_r == (nine_bit ? BITS_9 : BITS_8) - 4'h1) begin
              st_r   <= TX_STOP;
              line_r <= LINE_IDLE;
            end else begin
              line_r <= sh_r[0];
              sh_r   <= {1'b0, sh_r[8:1]};
            end
          end
        end
        TX_STOP: begin
          if (bit_end) begin
            st_r <= TX_IDLE;
          end
        end
        TX_BRK: begin
          if (bit_end) begin
            bitn_r <= bitn_r + 1'b1;
            if (bitn_r == BRK_BITS - 4'h1) begin
              st_r   <= TX_GAP;
              bitn_r <= '0;
              line_r <= LINE_IDLE;
            end
          end
        end
        TX_GAP: begin
          // idle after the break lets the far end start its oscillator
          if (bit_end) begin
            bitn_r <= bitn_r + 1'b1;
            if (bitn_r == BRK_GAP_BITS - 4'h1) begin
              st_r <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule : urw_tx_rmt
`default_nettype wire

// *** test/urw_line_sva.sv ***
// checker for the serial line and the receive end's status flags
// assumes one clock, sync active high reset, instantiated by the bench
`default_nettype none
module urw_line_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_line,
  input wire logic serial_port_enable,
  input wire logic continuous_rx_enable,
  input wire logic wakeup_set,
  input wire logic rd_data,
  input wire logic frame_err_flag,
  input wire logic overrun_err_flag,
  input wire logic rx_interrupt_flag,
  input wire logic wakeup_enable,
  input wire logic rx_idle_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ///////////////////////////////////////////////////////////////////////////
  // line edges seen while armed for wake; synchroniser adds two cycles
  sequence brk_fall_s;
    serial_port_enable && wakeup_enable && $fell(rx_line);
  endsequence
  sequence brk_rise_s;
    serial_port_enable && wakeup_enable && $rose(rx_line);
  endsequence
  port_off_flush_a: assert property ((!serial_port_enable)[*3] |->
    !frame_err_flag && !overrun_err_flag && !rx_interrupt_flag
    && !wakeup_enable) else $error("port disable left flags set");
  frame_keep_a: assert property ($fell(continuous_rx_enable)
    && serial_port_enable && rx_idle_status && !rd_data && !$past(rd_data)
    |=> $stable(frame_err_flag))
    else $error("receive disable changed framing flag");
  overrun_hold_a: assert property (overrun_err_flag
    && serial_port_enable && continuous_rx_enable |=> overrun_err_flag)
    else $error("overrun cleared on its own");
  overrun_clear_a: assert property (!continuous_rx_enable
    |=> !overrun_err_flag) else $error("overrun kept with receive off");
  wake_irq_a: assert property (brk_fall_s
    |-> ##[1:6] rx_interrupt_flag) else $error("no wake interrupt");
  wake_end_a: assert property (brk_rise_s
    |-> ##[1:6] !wakeup_enable) else $error("wake not ended by rise");
  wake_hold_a: assert property ((serial_port_enable
    && wakeup_enable && !rx_line)[*4] |=> wakeup_enable)
    else $error("wake dropped while line low");
  wake_quiet_a: assert property (wakeup_enable[*3]
    |-> rx_idle_status) else $error("receiving while armed for wake");
  wake_set_a: assert property (wakeup_set && serial_port_enable
    && !wakeup_enable && rx_line |=> wakeup_enable)
    else $error("wake arm ignored");
  empty_read_a: assert property (rd_data && !rx_interrupt_flag
    && rx_idle_status && serial_port_enable && continuous_rx_enable
    |=> $stable(overrun_err_flag) && $stable(frame_err_flag))
    else $error("empty read changed flags");
endmodule : urw_line_sva
`default_nettype wire

// *** test/uart_rx_errors_address_wakeup_test.sv ***
// bench: remote sender drives the receive end over one line interface
// assumes a 200 MHz clock; stimulus changes 1 ns after each rising edge
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module uart_rx_errors_address_wakeup_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic t9, r9, ad;
    logic [8:0] d;
    logic got;
    logic [7:0] b;
    logic n9, fe;
  } urw_row_t;
  // tx nine bits into an 8-bit receiver puts bit8 in the stop slot
  localparam urw_row_t ROWS [6] = '{
    '{1'h0, 1'h0, 1'h0, 9'h0A5, 1'h1, 8'hA5, 1'h0, 1'h0},
    '{1'h1, 1'h1, 1'h0, 9'h1C3, 1'h1, 8'hC3, 1'h1, 1'h0},
    '{1'h1, 1'h0, 1'h0, 9'h055, 1'h1, 8'h55, 1'h0, 1'h1},
    '{1'h1, 1'h1, 1'h1, 9'h03C, 1'h0, 8'h00, 1'h0, 1'h0},
    '{1'h1, 1'h1, 1'h1, 9'h17E, 1'h1, 8'h7E, 1'h1, 1'h0},
    // address matched: software drops the filter, data byte gets in
    '{1'h1, 1'h1, 1'h0, 9'h03C, 1'h1, 8'h3C, 1'h0, 1'h0}};
  logic clk = 1'h0, rst = 1'h1, spe, rx_on, nine, addr, wset, slp, rd;
  logic txv, t9, brk, n9, fe, ov, irq, we, idl, trdy, tbusy;
  logic [8:0] txd;
  logic [7:0] rxd;
  int err_count = 0, n_tests = 0, cyc = 0, k;
  always #2.5 clk = ~clk;
  urw_line_if urw_line_if_inst ();
  urw_tx_rmt urw_tx_rmt_inst (.clk(clk), .rst(rst), .ce(1'h1),
    .line(urw_line_if_inst), .tx_valid(txv), .tx_ready(trdy),
    .tx_data(txd), .nine_bit(t9), .send_break(brk), .tx_busy(tbusy));
  urw_rx_dev urw_rx_dev_inst (.clk(clk), .rst(rst), .ce(1'h1),
    .line(urw_line_if_inst), .serial_port_enable(spe),
    .continuous_rx_enable(rx_on), .nine_bit_rx_select(nine),
    .address_detect_enable(addr), .wakeup_set(wset), .sleep(slp),
    .rd_data(rd), .rx_data_reg(rxd), .rx_ninth_bit(n9),
    .frame_err_flag(fe), .overrun_err_flag(ov), .rx_interrupt_flag(irq),
    .wakeup_enable(we), .rx_idle_status(idl));
  urw_line_sva urw_line_sva_inst (.clk(clk), .rst(rst),
    .rx_line(urw_line_if_inst.rx_line), .serial_port_enable(spe),
    .continuous_rx_enable(rx_on), .wakeup_set(wset), .rd_data(rd),
    .frame_err_flag(fe), .overrun_err_flag(ov), .rx_interrupt_flag(irq),
    .wakeup_enable(we), .rx_idle_status(idl));
  ///////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // valid stays up on return so back-to-back pushes never drop it
  task automatic send(input logic [8:0] d);
    txd = d;
    txv = 1'h1;
    // ready is looked at settled, before the edge that takes the word
    while (!trdy) tick(1);
    tick(1);
  endtask : send
  task automatic quiet();
    txv = 1'h0;
    tick(4);
    for (int j = 0; j < 3000 && tbusy; j++) tick(1);
    tick(12);
  endtask : quiet
  task automatic read();
    rd = 1'h1;
    tick(1);
    rd = 1'h0;
    tick(2);
  endtask : read
  task automatic wrap_up();
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // whole run needs about 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    {spe, rx_on, nine, addr, wset, slp, rd, txv, t9, brk} = 10'h300;
    txd = 9'h000;
    tick(20);
    rst = 1'h0;
    `CHK("idle", 1'h1, idl)
    `CHK("irq", 1'h0, irq)
    `CHK("ovr", 1'h0, ov)
    `CHK("ready", 1'h1, trdy)
    tick(3);
    foreach (ROWS[i]) begin
      {t9, nine, addr} = {ROWS[i].t9, ROWS[i].r9, ROWS[i].ad};
      tick(1);
      send(ROWS[i].d);
      quiet();
      `CHK("irq", ROWS[i].got, irq)
      `CHK("ninth", ROWS[i].n9, n9)
      `CHK("frame", ROWS[i].fe, fe)
      `CHK("byte", ROWS[i].b, rxd)
      if (ROWS[i].got) read();
    end
    // framing flag survives receive disable, port disable flushes it
    {t9, nine, addr} = 3'h4;
    send(9'h055);
    quiet();
    rx_on = 1'h0;
    tick(3);
    `CHK("frame", 1'h1, fe)
    rx_on = 1'h1;
    spe = 1'h0;
    tick(3);
    `CHK("frame", 1'h0, fe)
    spe = 1'h1;
    t9 = 1'h0;
    read();
    `CHK("ovr", 1'h0, ov)
    `CHK("frame", 1'h0, fe)
    // fill the sender's buffer while the receiver overruns
    k = 0;
    while (trdy && k < 8) begin
      send(9'(8'h31 + k));
      k++;
    end
    `CHK("full", 1'h0, trdy)
    quiet();
    `CHK("ovr", 1'h1, ov)
    `CHK("byte", 8'h31, rxd)
    read();
    `CHK("byte", 8'h32, rxd)
    read();
    `CHK("irq", 1'h0, irq)
    // empty read must leave the standing overrun alone
    read();
    `CHK("ovr", 1'h1, ov)
    send(9'h077);
    quiet();
    `CHK("irq", 1'h0, irq)
    rx_on = 1'h0;
    tick(2);
    `CHK("ovr", 1'h0, ov)
    rx_on = 1'h1;
    // wake on break while asleep; receiver must be idle before arming
    slp = 1'h1;
    `CHK("idle", 1'h1, idl)
    wset = 1'h1;
    tick(1);
    wset = 1'h0;
    tick(2);
    `CHK("wake", 1'h1, we)
    brk = 1'h1;
    tick(1);
    brk = 1'h0;
    for (k = 0; k < 60 && !irq; k++) tick(1);
    `CHK("irq", 1'h1, irq)
    `CHK("wake", 1'h1, we)
    quiet();
    `CHK("wake", 1'h0, we)
    `CHK("busy", 1'h0, tbusy)
    `CHK("irq", 1'h1, irq)
    read();
    `CHK("irq", 1'h0, irq)
    // a plain character while asleep must not be received
    send(9'h0A5);
    quiet();
    `CHK("irq", 1'h0, irq)
    slp = 1'h0;
    wrap_up();
  end
endmodule : uart_rx_errors_address_wakeup_test
`default_nettype wire
